//--- verilog/pwm_duty_override_control.sv
// one complementary pwm generator with override and buffered updates
// assumes a software master on the plain strobe port and an external power stage
`default_nettype none
// How it works
// R1: center 0%: clear alt dead time first
// R2: center 100%: clear alt, duty=phase+2
// R3: edge 0%: clear both dead times first
// R4: edge 100%: clear both, duty=phase+1
// R5: override enables 11 plus sync drive data
// R6: override data 01 gives 0% duty
// R7: override data 10 gives 100% duty
// R8: center mode loads actives every two periods
// R9: override-off write during dead time deferred
// R10: release by dead time off or disable
// R11: center independent base phase applies two periods late
// R12: immediate update applies phase at once
// R13: dead time spoils full-time outputs; here only the 0% low side is chopped, 100% has no edge to chop
// R14: control bit 0 is immediate update
// R15: high inside duty window, dead time inserted
module pwm_duty_override_control (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_srst,
    input  wire logic [pwm_gen_pkg::ADDR_W-1:0] i_addr,     // register index
    input  wire logic [pwm_gen_pkg::DATA_W-1:0] i_wdata,    // write data
    input  wire logic                           i_wr,       // write strobe
    input  wire logic                           i_rd,       // read strobe
    output logic      [pwm_gen_pkg::DATA_W-1:0] o_rdata,    // read data, cycle after strobe
    output logic                                o_high_side,// output_high_side
    output logic                                o_low_side  // output_low_side
);
    import pwm_gen_pkg::*;

    // ========================================================
    // state of the generator outside the dead-time gate
    typedef struct packed {
        logic [DATA_W-1:0] ctrl;       // immediate update, alignment, time base
        logic [DATA_W-1:0] duty_b;     // buffered duty
        logic [DATA_W-1:0] phase_b;    // buffered phase/period
        logic [DATA_W-1:0] dt_b;       // buffered dead time
        logic [DATA_W-1:0] altdt_b;    // buffered alternate dead time
        logic [DATA_W-1:0] duty_a;     // active duty
        logic [DATA_W-1:0] phase_a;    // active phase/period
        logic [DATA_W-1:0] dt_a;       // active dead time
        logic [DATA_W-1:0] altdt_a;    // active alternate dead time
        logic [DATA_W-1:0] phase_p;    // phase waiting two more periods
        logic              phase_pv;   // phase_p holds a pending value
        logic [DATA_W-1:0] outctl;     // output_pin_control as written
        logic [DATA_W-1:0] ovr_a;      // override fields in force
        logic              mod_en;     // module_enable_bit
        logic [DATA_W-1:0] tmr;        // time base
        logic              down;       // center mode counting down
        logic              odd;        // center mode period parity
        logic [DATA_W-1:0] rdata;      // read data register
        pwm_pair_t         out;        // registered pin drive
    } gen_state_t;

    gen_state_t cur_ff;  // registered state
    gen_state_t nxt_ff;  // next state

    reg_req_t  req;          // bundled bus request
    pwm_pair_t dt_pair;      // pair after dead-time insertion
    logic      dt_busy;      // dead time being inserted
    logic      raw_high;     // duty-window comparison
    logic      center;       // center aligned mode
    logic      imm_upd;      // immediate update
    logic      period_end;   // end of a timer period
    logic      load_pt;      // active registers load now
    logic      ovr_on;       // override in force
    logic [DATA_W-1:0] dead_sel;  // dead time in use for this edge

    assign req    = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
    assign center = cur_ff.ctrl[CTRL_CENTER_BIT];
    assign imm_upd = cur_ff.ctrl[CTRL_IMM_UPD_BIT];  // R14
    assign ovr_on = cur_ff.ovr_a[OC_OVENH_BIT] | cur_ff.ovr_a[OC_OVENL_BIT];

    // period boundary: edge mode at wrap, center mode where the timer meets phase
    assign period_end = center ? (!cur_ff.down && cur_ff.tmr >= cur_ff.phase_a)
                               : (cur_ff.tmr >= cur_ff.phase_a);
    // center mode loads only on every other period
    assign load_pt = period_end && (!center || cur_ff.odd);  // R8

    // high inside the duty window: tmr below duty; at zero duty a dead time in
    // use at the period start still fires one raw pulse that chops the low side
    assign raw_high = cur_ff.mod_en
                      && ((cur_ff.tmr < cur_ff.duty_a)  // R15
                          || (cur_ff.tmr == RST_ZERO && dead_sel != RST_ZERO));  // R13
    // alternate dead time on the falling (center down) side
    assign dead_sel = (center && cur_ff.down) ? cur_ff.altdt_a : cur_ff.dt_a;

    // ========================================================
    // dead-time insertion; nonzero dead time chops 0% pulses, 100% has no edge to chop
    dead_time_gate u_dead (
        .i_core_clk  (i_core_clk),
        .i_srst      (i_srst),
        .i_raw_high  (raw_high),
        .i_dead      (dead_sel),
        .o_pair      (dt_pair),
        .o_inserting (dt_busy)
    );  // R13 R15

    // ========================================================
    // timer, register file, update transfer and override
    always_comb begin
        nxt_ff = cur_ff;

        // time base
        if (!cur_ff.mod_en) begin
            nxt_ff.tmr  = RST_ZERO;
            nxt_ff.down = 1'b0;
            nxt_ff.odd  = 1'b0;
        end else if (center) begin
            if (!cur_ff.down && cur_ff.tmr >= cur_ff.phase_a) begin
                nxt_ff.down = 1'b1;
                nxt_ff.tmr  = cur_ff.tmr - ONE;
            end else if (cur_ff.down && cur_ff.tmr == RST_ZERO) begin
                nxt_ff.down = 1'b0;
                nxt_ff.tmr  = cur_ff.tmr + ONE;
            end else begin
                nxt_ff.tmr = cur_ff.down ? cur_ff.tmr - ONE : cur_ff.tmr + ONE;
            end
            if (period_end) begin
                nxt_ff.odd = !cur_ff.odd;
            end
        end else begin
            nxt_ff.tmr = period_end ? RST_ZERO : cur_ff.tmr + ONE;
        end

        // buffered to active transfer
        if (imm_upd) begin
            // immediate update copies every value at once
            nxt_ff.duty_a   = cur_ff.duty_b;
            nxt_ff.phase_a  = cur_ff.phase_b;  // R12
            nxt_ff.dt_a     = cur_ff.dt_b;
            nxt_ff.altdt_a  = cur_ff.altdt_b;
            nxt_ff.phase_pv = 1'b0;
        end else if (load_pt) begin
            nxt_ff.duty_a  = cur_ff.duty_b;
            nxt_ff.dt_a    = cur_ff.dt_b;
            nxt_ff.altdt_a = cur_ff.altdt_b;
            if (center && cur_ff.ctrl[CTRL_INDEP_TB_BIT]) begin
                // phase goes through one extra stage: two periods late
                nxt_ff.phase_a  = cur_ff.phase_pv ? cur_ff.phase_p : cur_ff.phase_a;  // R11
                nxt_ff.phase_p  = cur_ff.phase_b;
                nxt_ff.phase_pv = (cur_ff.phase_b != cur_ff.phase_a);
            end else begin
                nxt_ff.phase_a  = cur_ff.phase_b;
                nxt_ff.phase_pv = 1'b0;
            end
        end

        // override follows the written value, at a load point (every other period end in center) when sync is set and the module is on
        if (!cur_ff.outctl[OC_OSYNC_BIT] || load_pt || !cur_ff.mod_en) begin
            // a release landing during dead time is held off until it ends, unless the module is off
            if (!(ovr_on && dt_busy && cur_ff.mod_en
                  && !cur_ff.outctl[OC_OVENH_BIT] && !cur_ff.outctl[OC_OVENL_BIT])) begin
                nxt_ff.ovr_a = cur_ff.outctl;  // R5 R9 R10
            end
        end

        // pin drive: per-side override, else dead-time gated pair
        nxt_ff.out = dt_pair;
        if (cur_ff.ovr_a[OC_OVENH_BIT]) begin
            nxt_ff.out.high_side = cur_ff.ovr_a[OC_OVDH_BIT];  // R6 R7
        end
        if (cur_ff.ovr_a[OC_OVENL_BIT]) begin
            nxt_ff.out.low_side = cur_ff.ovr_a[OC_OVDL_BIT];  // R6 R7
        end

        // register writes; software orders dead time clears before duty
        if (req.wr) begin
            unique case (req.addr)
                ADDR_CTRL:   nxt_ff.ctrl    = req.wdata & CTRL_MASK;
                ADDR_DUTY:   nxt_ff.duty_b  = req.wdata;
                ADDR_PHASE:  nxt_ff.phase_b = req.wdata;
                ADDR_DT:     nxt_ff.dt_b    = req.wdata;
                ADDR_ALTDT:  nxt_ff.altdt_b = req.wdata;
                ADDR_OUTCTL: nxt_ff.outctl  = req.wdata & OC_MASK;
                ADDR_MOD_EN: nxt_ff.mod_en  = req.wdata[0];
                default:     ;  // unmapped writes ignored
            endcase
        end

        // register reads, answered next cycle
        nxt_ff.rdata = RST_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CTRL:   nxt_ff.rdata = cur_ff.ctrl;
                ADDR_DUTY:   nxt_ff.rdata = cur_ff.duty_b;
                ADDR_PHASE:  nxt_ff.rdata = cur_ff.phase_b;
                ADDR_DT:     nxt_ff.rdata = cur_ff.dt_b;
                ADDR_ALTDT:  nxt_ff.rdata = cur_ff.altdt_b;
                ADDR_OUTCTL: nxt_ff.rdata = cur_ff.outctl;
                ADDR_STATUS: nxt_ff.rdata = cur_ff.tmr;
                ADDR_MOD_EN: nxt_ff.rdata = {15'h0000, cur_ff.mod_en};
                default:     nxt_ff.rdata = RST_ZERO;
            endcase
        end
    end

    // ========================================================
    // single state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cur_ff <= reset_image();
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // reset image of the state: low side on, phase at its reset period
    function automatic gen_state_t reset_image();
        gen_state_t img;
        img         = '0;
        img.phase_b = RST_PHASE;
        img.phase_a = RST_PHASE;
        img.out     = '{high_side: 1'b0, low_side: 1'b1};
        return img;
    endfunction

    assign o_rdata     = cur_ff.rdata;
    assign o_high_side = cur_ff.out.high_side;
    assign o_low_side  = cur_ff.out.low_side;
endmodule
`default_nettype wire

//--- verilog/pwm_gen_pkg.sv
// package for the single pwm generator: register map, field layouts, widths, states
// assumes one 125 MHz core clock and a plain strobe register port
`default_nettype none
package pwm_gen_pkg;
    // ========================================================
    // widths and timing
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned CLK_PERIOD_NS = 8;

    // ========================================================
    // register offsets (word index on the plain port)
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;  // mode and update control
    localparam logic [ADDR_W-1:0] ADDR_DUTY     = 4'h1;  // duty_cycle_reg
    localparam logic [ADDR_W-1:0] ADDR_PHASE    = 4'h2;  // phase_period_reg
    localparam logic [ADDR_W-1:0] ADDR_DT       = 4'h3;  // dead_time_reg
    localparam logic [ADDR_W-1:0] ADDR_ALTDT    = 4'h4;  // alt_dead_time_reg
    localparam logic [ADDR_W-1:0] ADDR_OUTCTL   = 4'h5;  // output_pin_control
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h6;  // timer value
    localparam logic [ADDR_W-1:0] ADDR_MOD_EN   = 4'h7;  // module_enable_bit

    // ========================================================
    // control register fields
    localparam int unsigned CTRL_IMM_UPD_BIT  = 0;  // immediate_update_enable
    localparam int unsigned CTRL_CENTER_BIT   = 1;  // 1 = center aligned
    localparam int unsigned CTRL_INDEP_TB_BIT = 2;  // independent_time_base
    localparam logic [DATA_W-1:0] CTRL_MASK = 16'h0007;

    // ========================================================
    // output control fields
    localparam int unsigned OC_OSYNC_BIT = 0;  // override synchronised to period
    localparam int unsigned OC_OVDL_BIT  = 6;  // override data, low side
    localparam int unsigned OC_OVDH_BIT  = 7;  // override data, high side
    localparam int unsigned OC_OVENL_BIT = 8;  // override_enable_low
    localparam int unsigned OC_OVENH_BIT = 9;  // override_enable_high
    localparam logic [DATA_W-1:0] OC_MASK = 16'h03c1;

    // ========================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_ZERO  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_PHASE = 16'h00ff;
    localparam logic [DATA_W-1:0] ONE       = 16'h0001;

    // dead-time sequencer states
    typedef enum logic [1:0] {
        DT_IDLE = 2'b00,
        DT_HIGH = 2'b01,
        DT_LOW  = 2'b10
    } dt_state_t;

    // register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // complementary output pair
    typedef struct packed {
        logic high_side;
        logic low_side;
    } pwm_pair_t;
endpackage
`default_nettype wire

//--- verilog/dead_time_gate.sv
// dead-time inserter: delays each rising edge of a complementary pair
// assumes the raw pair and dead time are synchronous to i_core_clk
`default_nettype none
module dead_time_gate (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_srst,
    input  wire logic                           i_raw_high,  // raw high-side demand
    input  wire logic [pwm_gen_pkg::DATA_W-1:0] i_dead,      // dead time in clocks
    output var  pwm_gen_pkg::pwm_pair_t         o_pair,      // gated outputs
    output logic                                o_inserting  // dead time running now
);
    import pwm_gen_pkg::*;

    // ========================================================
    // state record
    typedef struct packed {
        dt_state_t         st;     // which side waits for turn on
        logic [DATA_W-1:0] cnt;    // dead-time counter
        logic              last;   // previous raw demand
        pwm_pair_t         pair;   // registered outputs
    } dtg_state_t;

    dtg_state_t cur_ff;  // registered state
    dtg_state_t nxt_ff;  // next state

    // ========================================================
    // edge detect, then hold both sides off for i_dead clocks
    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.last = i_raw_high;
        if (cur_ff.last != i_raw_high) begin
            if (i_dead == RST_ZERO) begin
                // no dead time: switch straight over, nothing is inserted
                nxt_ff.pair.high_side = i_raw_high;
                nxt_ff.pair.low_side  = !i_raw_high;
                nxt_ff.st             = DT_IDLE;
            end else begin
                // any edge turns both off for exactly i_dead clocks
                nxt_ff.pair = '0;
                nxt_ff.cnt  = i_dead - ONE;
                nxt_ff.st   = i_raw_high ? DT_HIGH : DT_LOW;
            end
        end else if (cur_ff.st != DT_IDLE) begin
            if (cur_ff.cnt == RST_ZERO) begin
                // dead time over: turn on the waiting side
                nxt_ff.pair.high_side = (cur_ff.st == DT_HIGH);
                nxt_ff.pair.low_side  = (cur_ff.st == DT_LOW);
                nxt_ff.st             = DT_IDLE;
            end else begin
                nxt_ff.cnt = cur_ff.cnt - ONE;
            end
        end
    end

    // ========================================================
    // register, low side on after reset
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cur_ff <= '{st: DT_IDLE, cnt: RST_ZERO, last: 1'b0, pair: '{high_side: 1'b0, low_side: 1'b1}};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign o_pair      = cur_ff.pair;
    assign o_inserting = (cur_ff.st != DT_IDLE);
endmodule
`default_nettype wire

//--- test/pwm_ports_checker.sv
// port checker for the pwm generator
// assumes it is bound to pwm_duty_override_control
`default_nettype none
module pwm_ports_checker
    import pwm_gen_pkg::*;
(
    input wire logic                           i_core_clk,
    input wire logic                           i_srst,
    input wire logic [pwm_gen_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pwm_gen_pkg::DATA_W-1:0] i_wdata,
    input wire logic                           i_wr,
    input wire logic                           i_rd,
    input wire logic [pwm_gen_pkg::DATA_W-1:0] o_rdata,
    input wire logic                           o_high_side,
    input wire logic                           o_low_side
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // one clock domain, reset masks every check except reset_pins_a
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data not zero outside read slot");
    unmapped_read_a: assert property (i_rd && i_addr > ADDR_MOD_EN |=> o_rdata == '0)
        else $error("unmapped read not zero");
    reset_pins_a: assert property (disable iff (1'b0) i_srst |=> !o_high_side && o_low_side && o_rdata == '0)
        else $error("outputs not at reset level");
    no_overlap_a: assert property (!(o_high_side && o_low_side))
        else $error("both sides driven");
    ctrl_back_a: assert property (i_wr && i_addr == ADDR_CTRL ##2 i_rd && i_addr == ADDR_CTRL
        |=> o_rdata == ($past(i_wdata, 3) & CTRL_MASK)) else $error("control readback wrong");
    outctl_back_a: assert property (i_wr && i_addr == ADDR_OUTCTL ##2 i_rd && i_addr == ADDR_OUTCTL
        |=> o_rdata == ($past(i_wdata, 3) & OC_MASK)) else $error("output control readback wrong");
    ovr_low_a: assert property (i_wr && i_addr == ADDR_OUTCTL && i_wdata[9:6] == 4'b1101 && i_wdata[0]
        |-> ##[1:300] (!o_high_side && o_low_side)) else $error("override low not applied");
    ovr_high_a: assert property (i_wr && i_addr == ADDR_OUTCTL && i_wdata[9:6] == 4'b1110 && i_wdata[0]
        |-> ##[1:300] (o_high_side && !o_low_side)) else $error("override high not applied");
    // main scenarios
    high_seen_c: cover property (o_high_side);
    status_rd_c: cover property (i_rd && i_addr == ADDR_STATUS);
    ovr_wr_c: cover property (i_wr && i_addr == ADDR_OUTCTL && i_wdata[0]);
endmodule
bind pwm_duty_override_control pwm_ports_checker chk (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_high_side(o_high_side), .o_low_side(o_low_side));
`default_nettype wire

//--- test/power_stage_model.sv
// power stage model: counts on-cycles of each switch, flags shoot-through
// assumes the complementary pins are synchronous to i_core_clk
`default_nettype none
module power_stage_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic        i_high,
    input  wire logic        i_low,
    output var  logic [31:0] o_high_cnt,  // cycles high switch on
    output var  logic [31:0] o_low_cnt,   // cycles low switch on
    output var  logic        o_shoot      // sticky, both switches on
);
    timeunit 1ns;
    timeprecision 1ps;
    // counters run from reset
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_high_cnt <= '0;
            o_low_cnt  <= '0;
            o_shoot    <= 1'b0;
        end else begin
            o_high_cnt <= o_high_cnt + 32'(i_high);
            o_low_cnt  <= o_low_cnt + 32'(i_low);
            if (i_high && i_low) begin
                o_shoot <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/pwm_duty_override_control_tb.sv
// testbench for the pwm generator
// assumes the design, its package and the power stage model
`default_nettype none
module pwm_duty_override_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_gen_pkg::*;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_t;
    logic              i_core_clk, i_srst, i_wr, i_rd, o_high_side, o_low_side, shoot;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, v;
    logic [31:0]       hcnt, lcnt, dh, dl;
    int                failures, tests_run;
    row_t              rows [8] = '{'{ADDR_CTRL, 16'hffff, 16'h0007}, '{ADDR_OUTCTL, 16'hfcff, 16'h00c1},
        '{ADDR_DUTY, 16'h1234, 16'h1234}, '{ADDR_PHASE, 16'h0010, 16'h0010}, '{ADDR_DT, 16'h0003, 16'h0003},
        '{ADDR_ALTDT, 16'h0002, 16'h0002}, '{4'h8, 16'hffff, 16'h0000}, '{4'hf, 16'h1234, 16'h0000}};
    pwm_duty_override_control dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_high_side(o_high_side),
        .o_low_side(o_low_side));
    power_stage_model stage (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_high(o_high_side),
        .i_low(o_low_side), .o_high_cnt(hcnt), .o_low_cnt(lcnt), .o_shoot(shoot));
    // ==================================================
    // bus tasks, entered just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        d = o_rdata;
        @(posedge i_core_clk);
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // dead times cleared before duty, as software must
    task automatic cfg(input logic [15:0] c, ph, dt, alt, du);
        wr(ADDR_CTRL, c);
        wr(ADDR_PHASE, ph);
        wr(ADDR_ALTDT, alt);
        wr(ADDR_DT, dt);
        wr(ADDR_DUTY, du);
        repeat (200) @(posedge i_core_clk);
    endtask
    // on-cycles of each side over n cycles
    task automatic measure(input int n);
        @(negedge i_core_clk);
        dh = hcnt;
        dl = lcnt;
        repeat (n) @(posedge i_core_clk);
        @(negedge i_core_clk);
        dh = hcnt - dh;
        dl = lcnt - dl;
        @(posedge i_core_clk);
    endtask
    task automatic reset_chk();
        @(negedge i_core_clk);
        check("high_reset", 32'd0, 32'(o_high_side));
        check("low_reset", 32'd1, 32'(o_low_side));
        @(posedge i_core_clk);
        rd(ADDR_PHASE, v);
        check("phase_reset", 32'(RST_PHASE), 32'(v));
        rd(ADDR_DUTY, v);
        check("duty_reset", 32'(RST_ZERO), 32'(v));
    endtask
    task automatic results();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==================================================
    // clock and watchdog
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        failures++;
        results();
    end
    // ==================================================
    // main sequence
    initial begin
        {i_srst, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 4'h0, 16'h0000};
        failures = 0;
        tests_run = 0;
        repeat (6) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        reset_chk();
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, v);
            check("readback", 32'(rows[k].e), 32'(v));
        end
        wr(ADDR_MOD_EN, ONE);
        cfg(16'h0000, 16'h0010, 16'h0000, 16'h0000, 16'h0000);
        measure(100);
        check("edge_0_high", 32'd0, dh);
        cfg(16'h0000, 16'h0010, 16'h0000, 16'h0000, 16'h0011);
        measure(100);
        check("edge_100_low", 32'd0, dl);
        cfg(16'h0002, 16'h0010, 16'h0003, 16'h0000, 16'h0012);
        measure(100);
        check("center_100_high", 32'd100, dh);
        cfg(16'h0002, 16'h0010, 16'h0003, 16'h0000, 16'h0000);
        measure(100);
        check("center_0_low", 32'd100, dl);
        cfg(16'h0000, 16'h0010, 16'h0003, 16'h0000, 16'h0000);
        measure(100);
        check("edge_0_chop", 32'd1, 32'(dl < 100));
        cfg(16'h0000, 16'h0010, 16'h0003, 16'h0003, 16'h0008);
        measure(170);
        check("dead_gap", 32'd1, 32'(dh > 0 && dl > 0 && dh + dl < 170));
        wr(ADDR_OUTCTL, 16'h0341);
        repeat (300) @(posedge i_core_clk);
        measure(50);
        check("ovr_0_low", 32'd50, dl);
        wr(ADDR_OUTCTL, 16'h0381);
        repeat (300) @(posedge i_core_clk);
        measure(50);
        check("ovr_100_high", 32'd50, dh);
        wr(ADDR_MOD_EN, RST_ZERO);
        wr(ADDR_OUTCTL, RST_ZERO);
        wr(ADDR_MOD_EN, ONE);
        repeat (300) @(posedge i_core_clk);
        measure(170);
        check("ovr_released", 32'd1, 32'(dh > 0 && dl > 0));
        check("no_shoot", 32'd0, 32'(shoot));
        cfg(16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0000);
        do begin
            rd(ADDR_STATUS, v);
        end while (v >= 16'h00e0);
        wr(ADDR_DUTY, 16'h0100);
        repeat (8) @(negedge i_core_clk);
        check("buffered_duty", 32'd0, 32'(o_high_side));
        @(posedge i_core_clk);
        wr(ADDR_CTRL, ONE);
        wr(ADDR_DUTY, 16'h0100);
        repeat (8) @(negedge i_core_clk);
        check("immediate_duty", 32'd1, 32'(o_high_side));
        @(posedge i_core_clk);
        wr(ADDR_PHASE, 16'h0010);
        repeat (4) @(posedge i_core_clk);
        rd(ADDR_STATUS, v);
        check("immediate_phase", 32'd1, 32'(v <= 16'h0010));
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        reset_chk();
        results();
    end
endmodule
`default_nettype wire
